// ==== hw/cmp1_mux_pkg.sv ====
// Package with the address, field layout, codes and types of the select register.
package cmp1_mux_pkg;

  localparam logic [7:0] SEL_ADDR       = 8'h9E;
  localparam logic [3:0] SEL_PAGE       = 4'h0;
  localparam logic [7:0] SEL_RESET      = 8'hFF;
  localparam int         NEG_LSB        = 4;
  localparam int         POS_LSB        = 0;
  localparam logic [3:0] NEG_PIN_LAST   = 4'hA;
  localparam logic [3:0] NEG_RESERVED   = 4'hB;
  localparam logic [3:0] POS_PIN_LAST   = 4'hB;
  localparam logic [3:0] CODE_TOUCH     = 4'hC;
  localparam logic [3:0] CODE_HALF      = 4'hD;
  localparam logic [3:0] CODE_NEG_VREG  = 4'hE;
  localparam logic [3:0] CODE_NEG_GND   = 4'hF;
  localparam logic [3:0] CODE_POS_VBAT  = 4'hE;
  localparam logic [3:0] CODE_POS_VDD   = 4'hF;
  localparam int         PIN_COUNT      = 12;

  typedef enum logic [2:0] {
    SRC_PIN,
    SRC_TOUCH,
    SRC_HALF,
    SRC_VREG,
    SRC_VBAT,
    SRC_VDD,
    SRC_GND,
    SRC_NONE
  } source_t;

  typedef struct packed {
    source_t                source;
    logic [PIN_COUNT-1:0]   pin_onehot;
  } route_t;

endpackage

// ==== hw/cmp1_route_decode.sv ====
// Decoder from one four-bit selector to a route description.
`timescale 1ns/1ps
module cmp1_route_decode
  import cmp1_mux_pkg::*;
(
  input  wire logic [3:0] code_i,
  input  wire logic       negative_i,
  output route_t          route_o
);

  always_comb begin
    route_o.pin_onehot = '0;
    route_o.source     = SRC_NONE;
    if (negative_i) begin
      if (code_i <= NEG_PIN_LAST) begin
        route_o.source             = SRC_PIN;
        route_o.pin_onehot[code_i] = 1'b1;
      end else begin
        case (code_i)
          NEG_RESERVED:  route_o.source = SRC_NONE;
          CODE_TOUCH:    route_o.source = SRC_TOUCH;
          CODE_HALF:     route_o.source = SRC_HALF;
          CODE_NEG_VREG: route_o.source = SRC_VREG;
          CODE_NEG_GND:  route_o.source = SRC_GND;
          default:       route_o.source = SRC_NONE;
        endcase
      end
    end else begin
      if (code_i <= POS_PIN_LAST) begin
        route_o.source             = SRC_PIN;
        route_o.pin_onehot[code_i] = 1'b1;
      end else begin
        case (code_i)
          CODE_TOUCH:    route_o.source = SRC_TOUCH;
          CODE_HALF:     route_o.source = SRC_HALF;
          CODE_POS_VBAT: route_o.source = SRC_VBAT;
          CODE_POS_VDD:  route_o.source = SRC_VDD;
          default:       route_o.source = SRC_NONE;
        endcase
      end
    end
  end

endmodule

// ==== hw/comparator1_input_select.sv ====
// Select register for the second comparator's input multiplexers.
`timescale 1ns/1ps
// Notes on behaviour
// - Register decodes at special-function address 0x9E on page 0x0.
// - Bits 7:4 hold the negative-input selector, read and write.
// - Negative codes 0-10 pins, 11 reserved, then touch, half, regulator, ground.
// - Bits 3:0 hold the positive-input selector, read and write.
// - Positive codes 0-11 pins, then touch, half supply, battery, main supply.
module comparator1_input_select
  import cmp1_mux_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [3:0] sfr_page_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            sfr_hit_o,
  output logic      [3:0] negative_input_selector_o,
  output logic      [3:0] positive_input_selector_o,
  output route_t          negative_route_o,
  output route_t          positive_route_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.
  ////////////////////////////////////////////////////////////////////////////

  // True when the bus points at the select register on its page.
  function automatic logic addr_match(input logic [7:0] a,
                                      input logic [3:0] p);
    addr_match = (a == SEL_ADDR) && (p == SEL_PAGE);
  endfunction

  // Lowest register bit of selector field n; field 1 is the negative one.
  function automatic int field_lsb(input int n);
    if (n == 1) begin
      field_lsb = NEG_LSB;
    end else begin
      field_lsb = POS_LSB;
    end
  endfunction

  // Route shown while reset is held, for selector field n.
  function automatic route_t reset_route(input int n);
    reset_route.pin_onehot = '0;
    if (n == 1) begin
      reset_route.source = SRC_GND;
    end else begin
      reset_route.source = SRC_VDD;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and wiring.
  ////////////////////////////////////////////////////////////////////////////

  // Bus request qualified by address and page.
  logic       sel_w;
  logic       wr_hit_w;
  logic       rd_hit_w;

  // Selector fields, index 1 negative and index 0 positive.
  logic [3:0] wr_field_w [0:1];
  logic [3:0] field_ff   [0:1];
  logic [3:0] nxt_field  [0:1];

  // Whole register as software sees it.
  logic [7:0] select_w;

  // Registered read response.
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       hit_ff;
  logic       nxt_hit;

  // Decoded routes, one per selector field.
  route_t     route_w    [0:1];
  route_t     route_ff   [0:1];

  ////////////////////////////////////////////////////////////////////////////
  // Request decode.
  ////////////////////////////////////////////////////////////////////////////

  // Any other address or page leaves the register alone and clears the response to zero.
  assign sel_w    = addr_match(sfr_addr_i, sfr_page_i);
  assign wr_hit_w = sel_w && sfr_wr_i;
  assign rd_hit_w = sel_w && sfr_rd_i;

  ////////////////////////////////////////////////////////////////////////////
  // Write data split into selector fields.
  ////////////////////////////////////////////////////////////////////////////

  generate
    for (genvar n = 0; n < 2; n++) begin : g_wdata
      assign wr_field_w[n] = sfr_wdata_i[field_lsb(n) +: 4];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Selector fields.
  ////////////////////////////////////////////////////////////////////////////

  // Each field is stored as written, reserved codes included.
  generate
    for (genvar n = 0; n < 2; n++) begin : g_field

      always_comb begin
        nxt_field[n] = field_ff[n];
        if (wr_hit_w) begin
          nxt_field[n] = wr_field_w[n];
        end
      end

      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          field_ff[n] <= SEL_RESET[field_lsb(n) +: 4];
        end else begin
          field_ff[n] <= nxt_field[n];
        end
      end

    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register assembly.
  ////////////////////////////////////////////////////////////////////////////

  assign select_w = {field_ff[1], field_ff[0]};

  ////////////////////////////////////////////////////////////////////////////
  // Read response.
  ////////////////////////////////////////////////////////////////////////////

  // A read in the same cycle as a write returns the old value.
  always_comb begin
    nxt_rdata = 8'h00;
    nxt_hit   = 1'b0;
    if (rd_hit_w) begin
      nxt_rdata = select_w;
      nxt_hit   = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= 8'h00;
      hit_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      hit_ff   <= nxt_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Route decode.
  ////////////////////////////////////////////////////////////////////////////

  // Decoding the next field value keeps routes in step with the selectors.
  generate
    for (genvar n = 0; n < 2; n++) begin : g_route

      cmp1_route_decode i_cmp1_route_decode (
        .code_i     (nxt_field[n]),
        .negative_i (n == 1),
        .route_o    (route_w[n])
      );

      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          route_ff[n] <= reset_route(n);
        end else begin
          route_ff[n] <= route_w[n];
        end
      end

    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  ////////////////////////////////////////////////////////////////////////////

  // Every output is a flip-flop.
  assign sfr_rdata_o               = rdata_ff;
  assign sfr_hit_o                 = hit_ff;
  assign negative_input_selector_o = field_ff[1];
  assign positive_input_selector_o = field_ff[0];
  assign negative_route_o          = route_ff[1];
  assign positive_route_o          = route_ff[0];

endmodule

// ==== testbench/cmp1_sel_asserts.sv ====
// Checker for the comparator-1 select register ports.
`timescale 1ns/1ps
module cmp1_sel_asserts
  import cmp1_mux_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [3:0] sfr_page_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sfr_hit_o,
  input wire logic [3:0] negative_input_selector_o,
  input wire logic [3:0] positive_input_selector_o,
  input wire route_t     negative_route_o,
  input wire route_t     positive_route_o
);
  wire logic       sel = sfr_addr_i == SEL_ADDR && sfr_page_i == SEL_PAGE;
  wire logic [7:0] reg_v = {negative_input_selector_o,
                            positive_input_selector_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  read_hit_a: assert property (sfr_rd_i && sel |=> sfr_hit_o)
    else $error("read hit missing");
  stray_hit_a: assert property (!(sfr_rd_i && sel) |=> !sfr_hit_o)
    else $error("stray hit");
  read_data_a: assert property (sfr_rd_i && sel |=>
    sfr_rdata_o == $past(reg_v)) else $error("read data wrong");
  neg_write_a: assert property (sfr_wr_i && sel |=>
    negative_input_selector_o == $past(sfr_wdata_i[7:4]))
    else $error("negative write lost");
  pos_write_a: assert property (sfr_wr_i && sel |=>
    positive_input_selector_o == $past(sfr_wdata_i[3:0]))
    else $error("positive write lost");
  gnd_route_a: assert property (
    negative_input_selector_o == CODE_NEG_GND |->
    negative_route_o.source == SRC_GND) else $error("ground route wrong");
  vdd_route_a: assert property (
    positive_input_selector_o == CODE_POS_VDD |->
    positive_route_o.source == SRC_VDD) else $error("supply route wrong");
  reset_val_a: assert property ($rose(reset_n_i) |-> reg_v == SEL_RESET)
    else $error("reset value wrong");
endmodule
bind comparator1_input_select cmp1_sel_asserts i_cmp1_sel_asserts (.*);

// ==== testbench/test_comparator1_input_select.sv ====
// Self-checking bench for the comparator-1 select register.
`timescale 1ns/1ps
module test_comparator1_input_select
  import cmp1_mux_pkg::*;
;
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, hit;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  logic [3:0] page = 4'h0, neg, pos;
  route_t     nr, pr;
  int         bad_count = 0, total_checks = 0;
  comparator1_input_select i_comparator1_input_select (.clk_i(clk),
    .reset_n_i(rst_n), .sfr_addr_i(addr), .sfr_page_i(page), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
    .negative_input_selector_o(neg), .positive_input_selector_o(pos),
    .negative_route_o(nr), .positive_route_o(pr));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [14:0] rt(input logic [3:0] c, input logic n);
    if (c <= (n ? NEG_PIN_LAST : POS_PIN_LAST))
      return {SRC_PIN, 12'h001 << c};
    if (n && c == NEG_RESERVED) return {SRC_NONE, 12'h000};
    if (c == CODE_TOUCH) return {SRC_TOUCH, 12'h000};
    if (c == CODE_HALF) return {SRC_HALF, 12'h000};
    if (c == 4'hE) return {n ? SRC_VREG : SRC_VBAT, 12'h000};
    return {n ? SRC_GND : SRC_VDD, 12'h000};
  endfunction
  task automatic acc(input logic [1:0] op, input logic [7:0] a,
    input logic [7:0] d, input logic [3:0] p);
    {wr, rd, addr, wd, page} = {op, a, d, p};
    @(posedge clk) #1;
  endtask
  task automatic regchk(input logic [7:0] v);
    chk({neg, pos}, v);
    chk(nr, rt(v[7:4], 1'b1));
    chk(pr, rt(v[3:0], 1'b0));
    acc(2'b01, SEL_ADDR, 8'h00, SEL_PAGE);
    chk({hit, rdata}, {1'b1, v});
  endtask
  task automatic t_codes;
    for (int i = 0; i < 16; i++) begin
      acc(2'b10, SEL_ADDR, {i[3:0], 4'hF - i[3:0]}, SEL_PAGE);
      regchk({i[3:0], 4'hF - i[3:0]});
    end
    $display("code walk done");
  endtask
  task automatic t_miss;
    acc(2'b10, 8'h9F, 8'h12, SEL_PAGE);
    acc(2'b10, SEL_ADDR, 8'h12, 4'h1);
    acc(2'b01, 8'h9F, 8'h00, SEL_PAGE);
    chk({hit, rdata}, 9'h000);
    regchk(8'hF0);
    acc(2'b11, SEL_ADDR, 8'h5A, SEL_PAGE);
    chk({hit, rdata}, {1'b1, 8'hF0});
    regchk(8'h5A);
    $display("decode and overlap done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    regchk(SEL_RESET);
    $display("reset check done");
    t_codes();
    t_miss();
    {wr, rd} = 2'b00;
    print_verdict();
  end
  initial begin
    #20000;
    bad_count++;
    print_verdict();
  end
endmodule
